/* bench/dsc_net_master.sv */
// Purpose: Network master model: sends and receives framed characters.
// Assumes: Bit period is given in clocks per call; line idles high.
// Notes:   Can pull a stop bit low on request to provoke a frame error.
module dsc_net_master (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle high, as a pulled-up serial line rests
  initial rxd_o = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Start, data LSB first, parity, stops
  task automatic send(input logic [7:0] d, input logic [1:0] par,
                      input logic st2, input logic bad, input int div);
    logic [11:0] f;
    f = {2'b11, (par != 2'h0) ? (^d ^ par[1]) : 1'b1, d, 1'b0};
    if (bad)
      f[9 + (par != 2'h0)] = 1'b0;
    for (int i = 0; i < 10 + (par != 2'h0) + st2; i++) begin
      rxd_o <= f[i];
      repeat (div) @(posedge clk_i);
    end
    // A pulled-low first stop leaves the line low when it is the last bit sent; release it
    if (bad) begin
      rxd_o <= 1'b1;
      repeat (div) @(posedge clk_i);
    end
  endtask
  // Samples each bit at its centre; ok means start, parity, stop good
  task automatic get(output logic [7:0] d, output logic ok,
                     input logic [1:0] par, input logic st2, input int div);
    logic [11:0] f;
    int t;
    ok = 1'b0;
    d = 8'h00;
    t = 0;
    while (txd_i !== 1'b0 && t < 20000) begin
      @(posedge clk_i);
      t++;
    end
    repeat (div / 2) @(posedge clk_i);
    for (int i = 0; i < 10 + (par != 2'h0) + st2; i++) begin
      f[i] = txd_i;
      repeat (div) @(posedge clk_i);
    end
    d = f[8:1];
    ok = !f[0] && f[9 + (par != 2'h0)] &&
         (par == 2'h0 || f[9] == (^d ^ par[1]));
  endtask
endmodule

/* bench/dsc_serial_port_assertions.sv */
// Purpose: Port-level checks of the drive serial port.
// Assumes: Bound into dsc_serial_port; sees only its ports.
// Notes:   Settings writes are judged at the APB setup edge.
module dsc_serial_port_checker (
  input wire logic        CLOCK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        NET_SRC_I,
  input wire logic        TXD_O,
  input wire logic        NETWORK_LOSS_FLAG_O,
  input wire logic        TRIP_O,
  input wire logic [7:0]  TRIP_CODE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  // Write setup cycle; its answer comes one edge later
  wire wr_setup = PSEL_I && !PENABLE_I && PWRITE_I;
  ////////////////////////////////////////////////////////////////////////
  a_ready_single: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready after setup");
  a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside access");
  a_net_cfg_refused: assert property (wr_setup && NET_SRC_I &&
    PADDR_I[7:4] == 4'h0 && PADDR_I[1:0] == 2'h0 |=> PSLVERR_O)
    else $error("network settings write accepted");
  a_node_range: assert property (wr_setup && PADDR_I == 8'h04 &&
    (PWDATA_I == 32'h0 || PWDATA_I > 32'h20) |=> PSLVERR_O)
    else $error("bad node accepted");
  a_tmo_range: assert property (wr_setup && PADDR_I == 8'h08 &&
    PWDATA_I > 32'h270F |=> PSLVERR_O)
    else $error("bad timeout accepted");
  a_wait_range: assert property (wr_setup && PADDR_I == 8'h0C &&
    PWDATA_I > 32'h3E8 |=> PSLVERR_O)
    else $error("bad wait accepted");
  a_trip_code: assert property (
    TRIP_CODE_O == (TRIP_O ? 8'h3C : 8'h00))
    else $error("trip code mismatch");
  a_trip_cause: assert property (
    $rose(TRIP_O) |-> NETWORK_LOSS_FLAG_O)
    else $error("trip without link loss");
  a_start_bit: assert property ($fell(TXD_O) |-> !TXD_O [*4])
    else $error("start bit too short");
endmodule

bind dsc_serial_port dsc_serial_port_checker u_chk (
  .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .NET_SRC_I(NET_SRC_I), .TXD_O(TXD_O),
  .NETWORK_LOSS_FLAG_O(NETWORK_LOSS_FLAG_O), .TRIP_O(TRIP_O),
  .TRIP_CODE_O(TRIP_CODE_O));

/* bench/testbench.sv */
// Purpose: Self-checking bench of the drive serial port.
// Assumes: Short ms tick and bit dividers; baud code 6 is 4 clocks.
// Notes:   Random data from a fixed-seed xorshift.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic net = 1'b0, stopped = 1'b0, frst = 1'b0, st2, err, ok;
  logic [7:0]  paddr = 8'h00, b, rb;
  logic [31:0] pwdata = 32'h0, rd, seed = 32'h4E30A1A9;
  logic [5:0]  node;
  logic [1:0]  par;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          t;
  wire  [31:0] prdata;
  wire  [7:0]  tcode;
  wire         pready, pslverr, txd, rxd, loss, trip, decel, coast, irq;
  logic [7:0]  ca [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
  logic [31:0] cv [4] = '{32'h2006, 32'h1, 32'h0, 32'h0};
  logic [39:0] bad [8] = '{40'h0400000000, 40'h0400000021,
    40'h0800002710, 40'h0C000003E9, 40'h0000002007, 40'h0000002036,
    40'h0000005006, 40'h0000002003};
  // Clock of 50 ns
  always #25 clk = ~clk;
  dsc_serial_port #(.MS_CYCLES(20), .DIV_4800(16), .DIV_9600(8),
    .DIV_19200(4)) u_dsc_serial_port (
    .CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .NET_SRC_I(net), .RXD_I(rxd), .TXD_O(txd),
    .MOTOR_STOPPED_I(stopped), .FAULT_RESET_I(frst),
    .NETWORK_LOSS_FLAG_O(loss), .TRIP_O(trip), .TRIP_CODE_O(tcode),
    .DECEL_O(decel), .COAST_O(coast), .IRQ_O(irq));
  dsc_net_master u_net (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int div_of(input int c);
    return (c == 4) ? 16 : (c == 5) ? 8 : 4;
  endfunction
  function automatic logic [31:0] ctrl(input int e, input int c);
    return {17'h0, 3'(e), 3'h0, st2, 2'h0, par, 1'b0, 3'(c)};
  endfunction
  // Irq, trip, decel, coast, code expected with the motor stopped
  function automatic logic [31:0] fault(input int e);
    logic tr;
    tr = (e == 0) || (e == 1);
    return 32'({1'b1, tr, e == 1 || e == 4, e == 3, tr ? 8'h3C : 8'h00});
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds everything until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic n);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    net <= n;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cfg_check();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ca[i], 32'h0, 1'b0);
      check(rd, cv[i]);
    end
  endtask
  // Address byte then one data byte, then wait out the 36-bit gap
  task automatic msg(input logic [5:0] a, input logic bd);
    b = 8'(rnd());
    u_net.send({2'h0, a}, par, st2, 1'b0, 4);
    u_net.send(b, par, st2, bd, 4);
    repeat (160) @(posedge clk);
  endtask
  task automatic tx(input int div);
    b = 8'(rnd());
    apb(1'b1, 8'h10, 32'(b), 1'b0);
    t = 0;
    while (txd !== 1'b0 && t < 400) begin
      @(posedge clk);
      t++;
    end
    u_net.get(rb, ok, par, st2, div);
    check(32'({ok, rb}), 32'({1'b1, b}));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    par = 2'h0;
    st2 = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cfg_check();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ca[i], 32'h5, 1'b1);
      check(32'(err), 32'h1);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, bad[i][39:32], bad[i][31:0], 1'b0);
      check(32'(err), 32'h1);
    end
    cfg_check();
    // Random nodes, ending on the top of the range
    for (int k = 0; k < 7; k++) begin
      node = (k == 6) ? 6'h20 : 6'(rnd() % 32 + 1);
      apb(1'b1, 8'h04, 32'(node), 1'b0);
      apb(1'b0, 8'h04, 32'h0, 1'b0);
      check(rd, 32'(node));
    end
    // Each parity mode: good, foreign and broken messages, then a reply
    for (int p = 0; p < 3; p++) begin
      par = 2'(p);
      st2 = (p == 1);
      apb(1'b1, 8'h00, ctrl(2, 6), 1'b0);
      msg(node, 1'b0);
      apb(1'b0, 8'h14, 32'h0, 1'b0);
      check(32'(rd[8:0]), 32'({1'b1, b}));
      msg(node + 6'h1, 1'b0);
      apb(1'b0, 8'h14, 32'h0, 1'b0);
      check(32'(rd[8]), 32'h0);
      msg(node, 1'b1);
      apb(1'b0, 8'h14, 32'h0, 1'b0);
      check(32'(rd[8]), 32'h0);
      apb(1'b0, 8'h1C, 32'h0, 1'b0);
      check(32'(rd[4]), 32'h1);
      tx(4);
    end
    par = 2'h0;
    st2 = 1'b0;
    for (int c = 4; c < 7; c++) begin
      apb(1'b1, 8'h00, ctrl(2, c), 1'b0);
      tx(div_of(c));
    end
    // Reply held for a 3 ms wait after an accepted message
    apb(1'b1, 8'h0C, 32'h3, 1'b0);
    msg(node, 1'b0);
    tx(4);
    check(32'(t > 8 && t < 70), 32'h1);
    apb(1'b1, 8'h0C, 32'h0, 1'b0);
    // Watchdog of 20 ms under every fault response
    stopped <= 1'b1;
    apb(1'b1, 8'h20, 32'h8, 1'b0);
    apb(1'b1, 8'h08, 32'h2, 1'b0);
    for (int e = 0; e < 5; e++) begin
      frst <= 1'b1;
      @(posedge clk);
      frst <= 1'b0;
      apb(1'b1, 8'h00, ctrl(e, 6), 1'b0);
      msg(node, 1'b0);
      check(32'(loss), 32'h0);
      t = 0;
      while (loss !== 1'b1 && t < 1000) begin
        @(posedge clk);
        t++;
      end
      repeat (3) @(posedge clk);
      check(32'(t > 150 && t < 420), 32'h1);
      check(32'({irq, trip, decel, coast, tcode}), fault(e));
    end
    apb(1'b1, 8'h24, 32'h8, 1'b0);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    // Loss still standing, last data byte unread, link idle
    apb(1'b0, 8'h18, 32'h0, 1'b0);
    check(rd, 32'h6);
    report_and_stop();
  end
endmodule

/* verilog/dsc_params.svh */
// Purpose: Named constants of the drive serial port: map, fields, timing.
// Assumes: 20 MHz core clock, APB with one 32-bit word per register.
// Notes:   Definitions only; included by the package and the top module.
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Clock and timing
`define DSC_CLK_HZ        20000000
`define DSC_MS_CYC        (`DSC_CLK_HZ / 1000)
`define DSC_BIT_DIV(b)    ((`DSC_CLK_HZ + (b) / 2) / (b))
`define DSC_BAUD_4800     4800
`define DSC_BAUD_9600     9600
`define DSC_BAUD_19200    19200
`define DSC_GAP_BITS      6'd36
`define DSC_TICKS_PER_WD  4'd9

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define DSC_OFF_CTRL      8'h00
`define DSC_OFF_NODE      8'h04
`define DSC_OFF_TMO       8'h08
`define DSC_OFF_WAIT      8'h0C
`define DSC_OFF_TXDATA    8'h10
`define DSC_OFF_RXDATA    8'h14
`define DSC_OFF_STATUS    8'h18
`define DSC_OFF_ISTAT     8'h1C
`define DSC_OFF_IEN       8'h20
`define DSC_OFF_ICLR      8'h24

////////////////////////////////////////////////////////////////////////////
// Setting codes, limits and reset values
`define DSC_CODE_4800     3'h4
`define DSC_CODE_9600     3'h5
`define DSC_CODE_19200    3'h6
`define DSC_PAR_NONE      2'h0
`define DSC_PAR_EVEN      2'h1
`define DSC_PAR_ODD       2'h2
`define DSC_ERR_TRIP      3'h0
`define DSC_ERR_DECTRIP   3'h1
`define DSC_ERR_NONE      3'h2
`define DSC_ERR_COAST     3'h3
`define DSC_ERR_DECEL     3'h4
`define DSC_NODE_MIN      6'h01
`define DSC_NODE_MAX      6'h20
`define DSC_TMO_MAX       14'h270F
`define DSC_WAIT_MAX      10'h3E8
`define DSC_RST_BAUD      3'h6
`define DSC_RST_NODE      6'h01
`define DSC_TRIP_CODE     8'h3C

////////////////////////////////////////////////////////////////////////////
// Field positions; interrupt bits
`define DSC_F_PAR         4
`define DSC_F_STOP        8
`define DSC_F_ERR         12
`define DSC_F_RXVALID     8
`define DSC_IB_RX         0
`define DSC_IB_TXDONE     1
`define DSC_IB_MSG        2
`define DSC_IB_LOSS       3
`define DSC_IB_RXERR      4
`define DSC_NIRQ          5

`endif

/* verilog/dsc_pkg.sv */
// Purpose: Types of the drive serial port.
// Assumes: dsc_params.svh supplies DSC_NIRQ; the other widths and codes are written out here.
// Notes:   The whole block state is one packed struct.
`include "dsc_params.svh"
package dsc_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    dsc_rx_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    dsc_tx_t;
  typedef struct packed {
    logic rx_s1; logic rx_s2;
    logic [2:0] baud; logic [1:0] parity; logic stop2; logic [2:0] err_sel;
    logic [5:0] node; logic [13:0] tmo; logic [9:0] waitms;
    logic pready; logic pslverr; logic [31:0] prdata;
    dsc_rx_t rx_st; logic [15:0] rx_cnt; logic [2:0] rx_bit;
    logic [7:0] rx_sh; logic rx_stp; logic rx_perr;
    logic [7:0] rx_data; logic rx_valid;
    logic in_msg; logic addr_ok; logic [15:0] gap_cyc; logic [5:0] gap_bits;
    dsc_tx_t tx_st; logic [15:0] tx_cnt; logic [2:0] tx_bit;
    logic [7:0] tx_sh; logic tx_stp; logic tx_par;
    logic [7:0] tx_hold; logic tx_full; logic txd;
    logic [15:0] ms_cnt; logic [3:0] sub10; logic [13:0] wd_cnt; logic loss;
    logic [9:0] wait_cnt; logic waiting;
    logic [`DSC_NIRQ-1:0] ist; logic [`DSC_NIRQ-1:0] ien; logic irq;
    logic trip; logic decel; logic coast; logic trip_pend;
    logic [7:0] trip_code;
  } dsc_state_t;
endpackage

/* verilog/dsc_serial_port.sv */
// Purpose: Drive serial port: framed UART, node filter, reply wait,
//          watchdog with selectable fault response, APB settings.
// Assumes: One clock, async active-high reset; NET_SRC_I marks APB
//          cycles that come from the network side.
// Notes:   Message ends after a line gap; first byte is the node address.
// Operation
// - Node address 1 to 32, default 1; only matching messages accepted.
// - One or two stop bits, default one; sent and checked.
// - Port settings cannot be changed from the network side.
// - Comm error response: trip, decel+trip, none, coast, or decel.
// - Watchdog period 0.00 to 99.99 s in 0.01 s steps, 0 disables.
// - Reply waits 0 to 1000 ms after a complete accepted message.
// - Network-loss flag set on watchdog expiry, cleared by an accepted message or a zero period.
`include "dsc_params.svh"
module dsc_serial_port
  import dsc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `DSC_MS_CYC,
  parameter int unsigned DIV_4800  = `DSC_BIT_DIV(`DSC_BAUD_4800),
  parameter int unsigned DIV_9600  = `DSC_BIT_DIV(`DSC_BAUD_9600),
  parameter int unsigned DIV_19200 = `DSC_BIT_DIV(`DSC_BAUD_19200)
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        NET_SRC_I,
  input  wire logic        RXD_I,
  output logic             TXD_O,
  input  wire logic        MOTOR_STOPPED_I,
  input  wire logic        FAULT_RESET_I,
  output logic             NETWORK_LOSS_FLAG_O,
  output logic             TRIP_O,
  output logic      [7:0]  TRIP_CODE_O,
  output logic             DECEL_O,
  output logic             COAST_O,
  output logic             IRQ_O
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks: counters are 16 bits wide
  if (MS_CYCLES < 2 || MS_CYCLES > 65535 || DIV_4800 < 4 ||
      DIV_4800 > 65535 || DIV_9600 < 4 || DIV_9600 > 65535 ||
      DIV_19200 < 4 || DIV_19200 > 65535) begin : g_chk
    $error("dsc_serial_port: timing parameter out of range");
  end

  dsc_state_t s;
  dsc_state_t n;

  ////////////////////////////////////////////////////////////////////////
  // Bit period for the selected rate
  function automatic logic [15:0] bit_div(input logic [2:0] code);
    logic [15:0] d;
    d = 16'(DIV_19200);
    case (code)
      `DSC_CODE_4800: d = 16'(DIV_4800);
      `DSC_CODE_9600: d = 16'(DIV_9600);
      default:        d = 16'(DIV_19200);
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb begin
    logic [15:0] d;
    logic        rx_line;
    logic        setup;
    logic        acc;
    logic        bad;
    logic        cfg;
    logic        byte_done;
    logic        byte_err;
    logic        msg_done;
    logic        tx_done;
    logic        ms_tick;
    logic        wd_tick;
    logic        loss_ev;
    logic [`DSC_NIRQ-1:0] ev;
    d         = bit_div(s.baud);
    rx_line   = s.rx_s2;
    setup     = PSEL_I && !PENABLE_I;
    acc       = PSEL_I && PENABLE_I && s.pready;
    bad       = 1'b0;
    cfg       = 1'b0;
    byte_done = 1'b0;
    byte_err  = 1'b0;
    msg_done  = 1'b0;
    tx_done   = 1'b0;
    ms_tick   = 1'b0;
    wd_tick   = 1'b0;
    loss_ev   = 1'b0;
    ev        = '0;
    n         = s;

    // Two-flop synchroniser on the receive pin
    n.rx_s1 = RXD_I;
    n.rx_s2 = s.rx_s1;

    // APB setup: decide answer and error one cycle ahead of access
    n.pready  = setup;
    n.pslverr = 1'b0;
    n.prdata  = '0;
    if (setup) begin
      cfg = (PADDR_I == `DSC_OFF_CTRL) || (PADDR_I == `DSC_OFF_NODE) ||
            (PADDR_I == `DSC_OFF_TMO)  || (PADDR_I == `DSC_OFF_WAIT);
      case (PADDR_I)
        `DSC_OFF_CTRL: begin
          n.prdata[2:0] = s.baud;
          n.prdata[`DSC_F_PAR+:2] = s.parity;
          n.prdata[`DSC_F_STOP] = s.stop2;
          n.prdata[`DSC_F_ERR+:3] = s.err_sel;
          bad = PWRITE_I && (PWDATA_I[2:0] < `DSC_CODE_4800 ||
                PWDATA_I[2:0] > `DSC_CODE_19200 ||
                PWDATA_I[`DSC_F_PAR+:2] > `DSC_PAR_ODD ||
                PWDATA_I[`DSC_F_ERR+:3] > `DSC_ERR_DECEL);
        end
        `DSC_OFF_NODE: begin
          n.prdata[5:0] = s.node;
          bad = PWRITE_I && (PWDATA_I[5:0] < `DSC_NODE_MIN ||
                PWDATA_I[5:0] > `DSC_NODE_MAX || PWDATA_I[31:6] != '0);
        end
        `DSC_OFF_TMO: begin
          n.prdata[13:0] = s.tmo;
          bad = PWRITE_I && (PWDATA_I[13:0] > `DSC_TMO_MAX);
        end
        `DSC_OFF_WAIT: begin
          n.prdata[9:0] = s.waitms;
          bad = PWRITE_I && (PWDATA_I[9:0] > `DSC_WAIT_MAX);
        end
        `DSC_OFF_TXDATA: bad = !PWRITE_I || s.tx_full;
        `DSC_OFF_RXDATA: begin
          n.prdata[7:0] = s.rx_data;
          n.prdata[`DSC_F_RXVALID] = s.rx_valid;
          bad = PWRITE_I;
        end
        `DSC_OFF_STATUS: begin
          n.prdata[4:0] = {s.waiting, s.in_msg, s.loss, s.rx_valid,
                           s.tx_full || (s.tx_st != TX_IDLE)};
          bad = PWRITE_I;
        end
        `DSC_OFF_ISTAT: begin
          n.prdata[`DSC_NIRQ-1:0] = s.ist;
          bad = PWRITE_I;
        end
        `DSC_OFF_IEN:  n.prdata[`DSC_NIRQ-1:0] = s.ien;
        `DSC_OFF_ICLR: bad = !PWRITE_I;
        default:       bad = 1'b1;
      endcase
      // Network-side writes never reach port settings
      n.pslverr = bad || (PWRITE_I && cfg && NET_SRC_I);
    end

    // APB access: writes and read side effects land here only
    if (acc && !s.pslverr) begin
      if (PWRITE_I) begin
        case (PADDR_I)
          `DSC_OFF_CTRL: begin
            n.baud    = PWDATA_I[2:0];
            n.parity  = PWDATA_I[`DSC_F_PAR+:2];
            n.stop2   = PWDATA_I[`DSC_F_STOP];
            n.err_sel = PWDATA_I[`DSC_F_ERR+:3];
          end
          `DSC_OFF_NODE: n.node = PWDATA_I[5:0];
          `DSC_OFF_TMO:  n.tmo = PWDATA_I[13:0];
          `DSC_OFF_WAIT: n.waitms = PWDATA_I[9:0];
          `DSC_OFF_TXDATA: begin
            n.tx_hold = PWDATA_I[7:0];
            n.tx_full = 1'b1;
          end
          `DSC_OFF_IEN:  n.ien = PWDATA_I[`DSC_NIRQ-1:0];
          `DSC_OFF_ICLR: n.ist = s.ist & ~PWDATA_I[`DSC_NIRQ-1:0];
          default: ;
        endcase
      end else if (PADDR_I == `DSC_OFF_RXDATA) begin
        n.rx_valid = 1'b0;
      end
    end

    // Receiver, sampling each bit at its centre
    n.rx_cnt = (s.rx_cnt != '0) ? s.rx_cnt - 16'h0001 : '0;
    case (s.rx_st)
      RX_IDLE: if (!rx_line) begin
        n.rx_st  = RX_START;
        n.rx_cnt = d >> 1;
      end
      RX_START: if (s.rx_cnt == '0) begin
        n.rx_st  = rx_line ? RX_IDLE : RX_DATA; // glitch rejected
        n.rx_cnt = d - 16'h0001;
        n.rx_bit = '0;
        n.rx_stp = 1'b0;
        n.rx_perr = 1'b0;
      end
      RX_DATA: if (s.rx_cnt == '0) begin
        n.rx_sh  = {rx_line, s.rx_sh[7:1]};
        n.rx_bit = s.rx_bit + 3'h1;
        n.rx_cnt = d - 16'h0001;
        if (s.rx_bit == 3'h7) begin
          n.rx_st = (s.parity == `DSC_PAR_NONE) ? RX_STOP : RX_PAR;
        end
      end
      RX_PAR: if (s.rx_cnt == '0) begin
        n.rx_perr = rx_line != (^s.rx_sh ^ (s.parity == `DSC_PAR_ODD));
        n.rx_st   = RX_STOP;
        n.rx_cnt  = d - 16'h0001;
      end
      RX_STOP: if (s.rx_cnt == '0) begin
        n.rx_cnt = d - 16'h0001;
        if (!rx_line || !s.stop2 || s.rx_stp) begin
          n.rx_st   = RX_IDLE;
          byte_done = 1'b1;
          byte_err  = !rx_line || s.rx_perr;
        end else begin
          n.rx_stp = 1'b1;
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase

    // Message framing: address byte first, end on a line gap
    if (byte_done) begin
      n.gap_cyc  = '0;
      n.gap_bits = '0;
      if (!s.in_msg) begin
        n.in_msg  = 1'b1;
        n.addr_ok = !byte_err && (s.rx_sh == {2'h0, s.node});
      end else if (s.addr_ok && !byte_err) begin
        n.rx_data  = s.rx_sh;
        n.rx_valid = 1'b1;
        ev[`DSC_IB_RX] = 1'b1;
      end
      if (byte_err) begin
        n.addr_ok = 1'b0; // corrupt byte and the rest of its message dropped
        ev[`DSC_IB_RXERR] = 1'b1;
      end
    end else if (s.in_msg && s.rx_st == RX_IDLE) begin
      n.gap_cyc = (s.gap_cyc >= d - 16'h0001) ? '0 : s.gap_cyc + 16'h0001;
      if (s.gap_cyc >= d - 16'h0001) begin
        n.gap_bits = s.gap_bits + 6'h01;
      end
      if (s.gap_bits == `DSC_GAP_BITS) begin
        n.in_msg = 1'b0;
        msg_done = s.addr_ok;
        n.addr_ok = 1'b0;
      end
    end

    // Millisecond and hundredth-second ticks
    n.ms_cnt = s.ms_cnt + 16'h0001;
    if (s.ms_cnt == 16'(MS_CYCLES - 1)) begin
      n.ms_cnt = '0;
      ms_tick  = 1'b1;
      n.sub10  = (s.sub10 == `DSC_TICKS_PER_WD) ? '0 : s.sub10 + 4'h1;
      wd_tick  = (s.sub10 == `DSC_TICKS_PER_WD);
    end

    // Reply wait after each accepted message
    if (msg_done) begin
      n.waiting  = 1'b1;
      n.wait_cnt = '0;
      ev[`DSC_IB_MSG] = 1'b1;
    end else if (s.waiting && s.wait_cnt >= s.waitms) begin
      n.waiting = 1'b0;
    end else if (s.waiting && ms_tick) begin
      n.wait_cnt = s.wait_cnt + 10'h001;
    end

    // Watchdog; zero period disables it
    if (msg_done || s.tmo == '0) begin
      n.wd_cnt = '0;
      n.loss   = 1'b0;
    end else if (!s.loss) begin
      if (s.wd_cnt >= s.tmo) begin
        n.loss  = 1'b1;
        loss_ev = 1'b1;
        ev[`DSC_IB_LOSS] = 1'b1;
      end else if (wd_tick) begin
        n.wd_cnt = s.wd_cnt + 14'h0001;
      end
    end

    // Fault response to loss of communication
    if (FAULT_RESET_I) begin
      n.trip = 1'b0;
      n.decel = 1'b0;
      n.coast = 1'b0;
      n.trip_pend = 1'b0;
    end else if (loss_ev) begin
      case (s.err_sel)
        `DSC_ERR_TRIP:    n.trip = 1'b1;
        `DSC_ERR_DECTRIP: begin
          n.decel     = 1'b1;
          n.trip_pend = 1'b1;
        end
        `DSC_ERR_COAST:   n.coast = 1'b1;
        `DSC_ERR_DECEL:   n.decel = 1'b1;
        default: ;
      endcase
    end else if (s.trip_pend && MOTOR_STOPPED_I) begin
      n.trip      = 1'b1;
      n.trip_pend = 1'b0;
    end
    n.trip_code = n.trip ? `DSC_TRIP_CODE : 8'h00;

    // Transmitter; holds off until the reply wait has run out
    n.tx_cnt = (s.tx_cnt != '0) ? s.tx_cnt - 16'h0001 : '0;
    case (s.tx_st)
      TX_IDLE: if (s.tx_full && !s.waiting && !msg_done) begin
        n.tx_st   = TX_START;
        n.tx_sh   = s.tx_hold;
        n.tx_par  = ^s.tx_hold ^ (s.parity == `DSC_PAR_ODD);
        n.tx_full = 1'b0;
        n.txd     = 1'b0;
        n.tx_cnt  = d - 16'h0001;
      end
      TX_START: if (s.tx_cnt == '0) begin
        n.tx_st  = TX_DATA;
        n.txd    = s.tx_sh[0];
        n.tx_bit = '0;
        n.tx_cnt = d - 16'h0001;
      end
      TX_DATA: if (s.tx_cnt == '0) begin
        n.tx_cnt = d - 16'h0001;
        n.tx_bit = s.tx_bit + 3'h1;
        n.tx_sh  = {1'b0, s.tx_sh[7:1]};
        n.txd    = s.tx_sh[1];
        if (s.tx_bit == 3'h7) begin
          n.tx_st = (s.parity == `DSC_PAR_NONE) ? TX_STOP : TX_PAR;
          n.txd   = (s.parity == `DSC_PAR_NONE) ? 1'b1 : s.tx_par;
          n.tx_stp = 1'b0;
        end
      end
      TX_PAR: if (s.tx_cnt == '0) begin
        n.tx_st  = TX_STOP;
        n.txd    = 1'b1;
        n.tx_stp = 1'b0;
        n.tx_cnt = d - 16'h0001;
      end
      TX_STOP: if (s.tx_cnt == '0) begin
        n.tx_cnt = d - 16'h0001;
        if (s.stop2 && !s.tx_stp) begin
          n.tx_stp = 1'b1;
        end else begin
          n.tx_st = TX_IDLE;
          tx_done = 1'b1;
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
    ev[`DSC_IB_TXDONE] = tx_done;

    // Sticky status: a new event beats a clear in the same cycle
    n.ist = n.ist | ev;
    n.irq = |(n.ist & n.ien);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s         <= '0;
      s.rx_s1   <= 1'b1;
      s.rx_s2   <= 1'b1;
      s.txd     <= 1'b1;
      s.baud    <= `DSC_RST_BAUD;
      s.node    <= `DSC_RST_NODE;
      s.parity  <= `DSC_PAR_NONE;
      s.err_sel <= `DSC_ERR_NONE;
      s.rx_st   <= RX_IDLE;
      s.tx_st   <= TX_IDLE;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign PRDATA_O            = s.prdata;
  assign PREADY_O            = s.pready;
  assign PSLVERR_O           = s.pslverr;
  assign TXD_O               = s.txd;
  assign NETWORK_LOSS_FLAG_O = s.loss;
  assign TRIP_O              = s.trip;
  assign TRIP_CODE_O         = s.trip_code;
  assign DECEL_O             = s.decel;
  assign COAST_O             = s.coast;
  assign IRQ_O               = s.irq;

endmodule
